/* rtl/spg_defs.svh */
// offsets, field positions, reset values and timing counts for the swipe and palm engine
`ifndef SPG_DEFS_SVH
`define SPG_DEFS_SVH
`define SPG_OFS_ENABLE 8'h00
`define SPG_OFS_INIT_DIST 8'h04
`define SPG_OFS_CONS_DIST 8'h08
`define SPG_OFS_TIMES 8'h0C
`define SPG_OFS_LIMITS 8'h10
`define SPG_OFS_STATUS 8'h14
`define SPG_OFS_REL 8'h18
`define SPG_OFS_GEST 8'h1C
`define SPG_EN_SWIPE_LSB 0
`define SPG_EN_HOLD_LSB 4
`define SPG_EN_PALM 8
`define SPG_EN_EVENT_MODE 9
`define SPG_ST_EVENT 9
`define SPG_ENABLE_RST 32'h0000_01FF
`define SPG_INIT_DIST_RST 32'h0064_0064
`define SPG_CONS_DIST_RST 32'h0032_0032
`define SPG_TIMES_RST 32'h012C_0096
`define SPG_LIMITS_RST 32'h0014_1440
`define SPG_ANGLE_64X 64
`define SPG_MS_NS 1000000
`define SPG_CLK_NS 4
`endif

/* rtl/spg_pkg.sv */
// types shared by the swipe and palm engine
package spg_pkg;
  // tracking state of the first finger
  typedef enum logic [1:0] {
    SPG_IDLE,
    SPG_TRACK,
    SPG_SWIPED,
    SPG_HELD
  } spg_state_t;
  // signed displacement between two coordinates
  typedef logic signed [16:0] spg_disp_t;
endpackage

/* rtl/spg_ms_timer.sv */
// millisecond tick divider and saturating elapsed-time counter
`include "spg_defs.svh"
module spg_ms_timer #(
  parameter int MS_CYCLES = `SPG_MS_NS / `SPG_CLK_NS
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  output logic [15:0] ms_o
);
  // the divider must hold at least one cycle
  if (MS_CYCLES < 1) begin : g_bad
    $error("MS_CYCLES must be at least 1");
  end
  logic [31:0] div; // cycles within the current millisecond
  // divider restarts with the count so that the first ms is a whole one
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div <= 32'h0;
      ms_o <= 16'h0;
    end else if (clr_i) begin
      div <= 32'h0;
      ms_o <= 16'h0;
    end else if (div == 32'(MS_CYCLES - 1)) begin
      div <= 32'h0;
      // saturate so a long press never wraps back under a limit
      if (ms_o != 16'hFFFF) begin
        ms_o <= ms_o + 16'h1;
      end
    end else begin
      div <= div + 32'h1;
    end
  end
endmodule

/* rtl/spg_swipe_chk.sv */
// combinational swipe distance, axis, direction and angle check
module spg_swipe_chk (
  input wire spg_pkg::spg_disp_t dx_i,
  input wire spg_pkg::spg_disp_t dy_i,
  input wire logic [15:0] thr_x_i,
  input wire logic [15:0] thr_y_i,
  input wire logic [7:0] angle_i,
  output logic [15:0] ax_o,
  output logic [15:0] ay_o,
  output logic x_type_o,
  output logic neg_o,
  output logic hit_o
);
  `include "spg_defs.svh"
  logic [15:0] major; // displacement along the dominant axis
  logic [15:0] minor; // displacement across it
  logic [23:0] lhs; // 64 times the minor displacement
  logic [23:0] rhs; // angle setting times the major displacement
  // magnitudes never exceed 16 bits for unsigned 16-bit coordinates
  assign ax_o = dx_i[16] ? 16'(-dx_i) : dx_i[15:0];
  assign ay_o = dy_i[16] ? 16'(-dy_i) : dy_i[15:0];
  assign x_type_o = ax_o >= ay_o;
  assign major = x_type_o ? ax_o : ay_o;
  assign minor = x_type_o ? ay_o : ax_o;
  assign neg_o = x_type_o ? dx_i[16] : dy_i[16];
  assign lhs = {2'b00, minor, 6'h00};
  assign rhs = 24'(major * angle_i);
  assign hit_o = (x_type_o ? ax_o >= thr_x_i : ay_o >= thr_y_i) && lhs <= rhs && major != 16'h0;
endmodule

/* rtl/spg_engine.sv */
// swipe, swipe-and-hold and palm gesture engine with AXI4-Lite registers
// Behaviour
// - away from origin positive, toward negative
// - swipe axis follows dominant movement
// - initial distance per axis must be travelled
// - initial distance within swipe time limit
// - angle within limit to one axis
// - swipe flag lasts one processing cycle
// - relative motion reported every cycle
// - angle setting is 64 times tangent
// - swipe displacement copied to gesture outputs
// - hold stationary for hold time after swipe
// - hold flag stays until finger release
// - without hold, repeat swipes past consecutive distance
// - no time limit on consecutive swipes
// - same axis consecutive, other axis initial
// - palm when touched channels reach threshold
// - palm stays until no touch remains
// - each gesture gated by enable mask
// - only first finger data is evaluated
// - event mode raises event on report
`include "spg_defs.svh"
module spg_engine #(
  parameter int MS_CYCLES = `SPG_MS_NS / `SPG_CLK_NS,
  parameter int CH_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic cycle_stb_i,
  input wire logic touch_i,
  input wire logic [15:0] pos_x_i,
  input wire logic [15:0] pos_y_i,
  input wire logic [CH_W-1:0] ch_count_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [8:0] gesture_o,
  output logic gesture_event_o
);
  if (CH_W < 1 || CH_W > 8) begin : g_bad
    $error("CH_W must be 1 to 8");
  end
  logic [31:0] reg_en; // enable mask and event mode
  logic [31:0] reg_init; // initial distances, y high
  logic [31:0] reg_cons; // consecutive distances, y high
  logic [31:0] reg_times; // swipe time low, hold time high
  logic [31:0] reg_lim; // angle, tap distance, palm threshold
  spg_pkg::spg_state_t state; // first finger tracking state
  logic [15:0] anchor_x; // touch start, last swipe or hold-mode move coordinate
  logic [15:0] anchor_y;
  logic [15:0] prev_x; // previous cycle coordinate
  logic [15:0] prev_y;
  logic last_x; // last swipe was on the x axis
  logic [3:0] swipe; // one-cycle swipe flags x+ x- y+ y-
  logic [3:0] hold; // latched swipe-and-hold flags
  logic palm; // latched flat hand flag
  logic evt; // pending gesture event
  logic [15:0] rel_x; // per-cycle movement
  logic [15:0] rel_y;
  logic [15:0] gest_x; // displacement behind the last swipe
  logic [15:0] gest_y;
  logic [15:0] ms; // ms since touch, first swipe or hold-mode move
  logic tmr_clr; // restart elapsed time
  spg_pkg::spg_disp_t dx; // movement from anchor
  spg_pkg::spg_disp_t dy;
  logic [15:0] ax; // movement magnitudes
  logic [15:0] ay;
  logic x_type; // dominant axis is x
  logic neg; // moving toward origin
  logic hit; // swipe conditions met
  logic [15:0] thr_x; // distance thresholds in use
  logic [15:0] thr_y;
  logic [1:0] dir; // flag index of the current movement
  logic hold_mode; // any swipe-and-hold enabled
  logic still; // within the stationary radius
  logic [8:0] rep_new; // flags rising this processing cycle
  logic wr_go; // write address and data both taken
  logic [31:0] wmask; // byte lanes from wstrb

  // decode a register offset into a hit for read and write
  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= `SPG_OFS_GEST;
  endfunction

  // only the first finger's coordinates feed this path
  assign dx = $signed({1'b0, pos_x_i}) - $signed({1'b0, anchor_x});
  assign dy = $signed({1'b0, pos_y_i}) - $signed({1'b0, anchor_y});
  // same axis uses consecutive, other axis initial
  assign thr_x = (state == spg_pkg::SPG_SWIPED && last_x) ? reg_cons[15:0] : reg_init[15:0];
  assign thr_y = (state == spg_pkg::SPG_SWIPED && !last_x) ? reg_cons[31:16] : reg_init[31:16];

  spg_swipe_chk u_chk (
    .dx_i(dx),
    .dy_i(dy),
    .thr_x_i(thr_x),
    .thr_y_i(thr_y),
    .angle_i(reg_lim[7:0]),
    .ax_o(ax),
    .ay_o(ay),
    .x_type_o(x_type),
    .neg_o(neg),
    .hit_o(hit)
  );
  assign dir = {~x_type, neg};
  assign hold_mode = |reg_en[`SPG_EN_HOLD_LSB +: 4];
  assign still = ax <= {8'h00, reg_lim[15:8]} && ay <= {8'h00, reg_lim[15:8]};

  // timer restarts on a new touch, a first swipe from tracking or a move while holding; a late hit must not restart it
  assign tmr_clr = cycle_stb_i && (!touch_i || state == spg_pkg::SPG_IDLE ||
                   (state == spg_pkg::SPG_TRACK && hit && ms <= reg_times[15:0]) ||
                   (state == spg_pkg::SPG_SWIPED && hold_mode && !still));
  spg_ms_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tmr (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clr_i(tmr_clr),
    .ms_o(ms)
  );

  // finger tracking state machine, advanced once per processing cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= spg_pkg::SPG_IDLE;
      anchor_x <= 16'h0;
      anchor_y <= 16'h0;
      last_x <= 1'b0;
    end else if (cycle_stb_i) begin
      if (!touch_i) begin
        state <= spg_pkg::SPG_IDLE;
      end else begin
        unique case (state)
          spg_pkg::SPG_IDLE: begin
            anchor_x <= pos_x_i;
            anchor_y <= pos_y_i;
            state <= spg_pkg::SPG_TRACK;
          end
          spg_pkg::SPG_TRACK: begin
            if (hit && ms <= reg_times[15:0]) begin
              anchor_x <= pos_x_i;
              anchor_y <= pos_y_i;
              last_x <= x_type;
              state <= spg_pkg::SPG_SWIPED;
            end
          end
          spg_pkg::SPG_SWIPED: begin
            if (hold_mode) begin
              // re-anchor on movement, hold after hold time
              if (!still) begin
                anchor_x <= pos_x_i;
                anchor_y <= pos_y_i;
              end else if (ms >= reg_times[31:16]) begin
                state <= spg_pkg::SPG_HELD;
              end
            end else if (hit) begin
              // consecutive swipes ignore the time limit
              anchor_x <= pos_x_i;
              anchor_y <= pos_y_i;
              last_x <= x_type;
            end
          end
          spg_pkg::SPG_HELD: begin
            state <= spg_pkg::SPG_HELD;
          end
        endcase
      end
    end
  end

  // gesture flags, updated only on processing cycles
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      swipe <= 4'h0;
      hold <= 4'h0;
      gest_x <= 16'h0;
      gest_y <= 16'h0;
    end else if (cycle_stb_i) begin
      // a swipe flag is cleared at the next processing cycle
      swipe <= 4'h0;
      if (touch_i && hit && ((state == spg_pkg::SPG_TRACK && ms <= reg_times[15:0]) ||
          (state == spg_pkg::SPG_SWIPED && !hold_mode))) begin
        swipe[dir] <= reg_en[`SPG_EN_SWIPE_LSB + 32'(dir)];
        gest_x <= dx[15:0];
        gest_y <= dy[15:0];
      end
      // hold flags clear only on release
      if (!touch_i) begin
        hold <= 4'h0;
      end else if (state == spg_pkg::SPG_SWIPED && hold_mode && still && ms >= reg_times[31:16]) begin
        hold[{~last_x, gest_x[15] & last_x | gest_y[15] & ~last_x}] <=
          reg_en[`SPG_EN_HOLD_LSB + 32'({~last_x, gest_x[15] & last_x | gest_y[15] & ~last_x})];
      end
    end
  end

  // palm flag: set on the channel count, cleared on a full release
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      palm <= 1'b0;
    end else if (cycle_stb_i) begin
      if (reg_en[`SPG_EN_PALM] && ch_count_i >= CH_W'(reg_lim[23:16]) && ch_count_i != '0) begin
        palm <= 1'b1;
      // clear only when no touch remains
      end else if (ch_count_i == '0 && !touch_i) begin
        palm <= 1'b0;
      end
    end
  end

  // relative motion of the first finger, zero while untouched
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_x <= 16'h0;
      prev_y <= 16'h0;
      rel_x <= 16'h0;
      rel_y <= 16'h0;
    end else if (cycle_stb_i) begin
      prev_x <= pos_x_i;
      prev_y <= pos_y_i;
      if (touch_i && state != spg_pkg::SPG_IDLE) begin
        rel_x <= pos_x_i - prev_x;
        rel_y <= pos_y_i - prev_y;
      end else begin
        rel_x <= 16'h0;
        rel_y <= 16'h0;
      end
    end
  end

  // a rising flag in event mode opens a host window until software acknowledges
  assign rep_new = {palm, hold, swipe} & ~gesture_o;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gesture_o <= 9'h0;
      evt <= 1'b0;
    end else begin
      gesture_o <= {palm, hold, swipe};
      // set wins over a same-cycle acknowledge
      if (reg_en[`SPG_EN_EVENT_MODE] && |rep_new) begin
        evt <= 1'b1;
      end else if (wr_go && s_axi_awaddr == `SPG_OFS_STATUS && s_axi_wstrb[1] && s_axi_wdata[`SPG_ST_EVENT]) begin
        evt <= 1'b0;
      end
    end
  end
  assign gesture_event_o = evt;

  // write channel: address and data are taken together, one response at a time
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // configuration registers with byte-lane writes
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_en <= `SPG_ENABLE_RST;
      reg_init <= `SPG_INIT_DIST_RST;
      reg_cons <= `SPG_CONS_DIST_RST;
      reg_times <= `SPG_TIMES_RST;
      reg_lim <= `SPG_LIMITS_RST;
    end else if (wr_go) begin
      unique case (s_axi_awaddr)
        `SPG_OFS_ENABLE: reg_en <= ((reg_en & ~wmask) | (s_axi_wdata & wmask)) & 32'h0000_03FF;
        `SPG_OFS_INIT_DIST: reg_init <= (reg_init & ~wmask) | (s_axi_wdata & wmask);
        `SPG_OFS_CONS_DIST: reg_cons <= (reg_cons & ~wmask) | (s_axi_wdata & wmask);
        `SPG_OFS_TIMES: reg_times <= (reg_times & ~wmask) | (s_axi_wdata & wmask);
        `SPG_OFS_LIMITS: reg_lim <= ((reg_lim & ~wmask) | (s_axi_wdata & wmask)) & 32'h00FF_FFFF;
        default: reg_en <= reg_en;
      endcase
    end
  end

  // write response: slave error for an unmapped offset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(s_axi_awaddr) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one outstanding read, data registered
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr)
        `SPG_OFS_ENABLE: s_axi_rdata <= reg_en;
        `SPG_OFS_INIT_DIST: s_axi_rdata <= reg_init;
        `SPG_OFS_CONS_DIST: s_axi_rdata <= reg_cons;
        `SPG_OFS_TIMES: s_axi_rdata <= reg_times;
        `SPG_OFS_LIMITS: s_axi_rdata <= reg_lim;
        `SPG_OFS_STATUS: s_axi_rdata <= {22'h0, evt, gesture_o};
        `SPG_OFS_REL: s_axi_rdata <= {rel_y, rel_x};
        `SPG_OFS_GEST: s_axi_rdata <= {gest_y, gest_x};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_swipe_pulse;
    !cycle_stb_i |=> $stable(swipe);
  endproperty
  a_swipe_pulse: assert property (p_swipe_pulse) else $error("swipe flag changed off a cycle strobe");
  property p_hold_keep;
    (|hold && !(cycle_stb_i && !touch_i)) |=> |hold;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold flag dropped while touched");
  property p_hold_clear;
    (cycle_stb_i && !touch_i) |=> hold == 4'h0 ##1 state == spg_pkg::SPG_IDLE;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("hold flag kept after release");
  property p_palm_set;
    (cycle_stb_i && reg_en[`SPG_EN_PALM] && ch_count_i >= CH_W'(reg_lim[23:16]) && ch_count_i != '0) |=> palm;
  endproperty
  a_palm_set: assert property (p_palm_set) else $error("palm not set at threshold");
  property p_palm_keep;
    (palm && !(cycle_stb_i && ch_count_i == '0 && !touch_i)) |=> palm;
  endproperty
  a_palm_keep: assert property (p_palm_keep) else $error("palm cleared with touch present");
  property p_mask;
    cycle_stb_i |=> (swipe & ~$past(reg_en[3:0])) == 4'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("disabled swipe reported");
  property p_release;
    (cycle_stb_i && !touch_i) |=> state == spg_pkg::SPG_IDLE && rel_x == 16'h0;
  endproperty
  a_release: assert property (p_release) else $error("state kept after release");
  property p_rel;
    (cycle_stb_i && touch_i && state != spg_pkg::SPG_IDLE) |=> rel_x == 16'($past(pos_x_i) - $past(prev_x));
  endproperty
  a_rel: assert property (p_rel) else $error("relative x wrong");
  property p_event;
    (reg_en[`SPG_EN_EVENT_MODE] && |rep_new) |=> evt && gesture_event_o;
  endproperty
  a_event: assert property (p_event) else $error("event not raised");
  c_swipe: cover property (cycle_stb_i && |swipe);
  c_hold: cover property (|hold);
  c_palm: cover property ($rose(palm));
endmodule

/* tb/spg_host.sv */
// host model: register bus master that reads and sets the gesture engine
module spg_host (
  input wire logic clk_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic aw_t, b_t, ar_t, r_t; // handshakes seen at the last edge
  logic [31:0] rd_q; // read data taken with the answer
  logic [1:0] rs_q; // response code taken with the answer
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // record handshakes from pre-edge values, so no race with the slave
  always @(posedge clk_i) begin
    aw_t <= awvalid_o & awready_i & wvalid_o & wready_i;
    ar_t <= arvalid_o & arready_i;
    b_t <= bvalid_i & bready_o;
    r_t <= rvalid_i & rready_o;
    if (bvalid_i & bready_o) rs_q <= bresp_i;
    if (rvalid_i & rready_o) begin
      rd_q <= rdata_i;
      rs_q <= rresp_i;
    end
  end
  // bounded wait for one handshake; a stuck slave returns ok low
  task automatic hs(input int k, output bit ok);
    int n;
    ok = 0;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk_i);
      #1;
      ok = ((k == 0) ? aw_t : (k == 1) ? b_t : (k == 2) ? ar_t : r_t) === 1'b1;
    end
  endtask
  // address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output bit ok);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= 4'hF;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    hs(0, ok);
    awvalid_o <= 1'b0;
    wvalid_o <= 1'b0;
    if (ok) hs(1, ok);
    bready_o <= 1'b0;
    r = rs_q;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    hs(2, ok);
    arvalid_o <= 1'b0;
    if (ok) hs(3, ok);
    rready_o <= 1'b0;
    d = rd_q;
    r = rs_q;
  endtask
endmodule

/* tb/swipe_palm_gesture_engine_test.sv */
// self-checking bench for the swipe and palm engine
`include "spg_defs.svh"
module swipe_palm_gesture_engine_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, nrst = 0, stb = 0, touch = 0;
  logic [15:0] px = 0, py = 0; // finger position driven to the engine
  logic [7:0] cnt = 0; // touched channel count
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [8:0] gest; // gesture flags
  logic evt;
  int failures = 0, n_compared = 0;
  logic [31:0] seed = 32'd63847; // fixed so runs repeat
  logic [31:0] dat;
  logic [1:0] rsp;
  bit ok;
  logic [15:0] d, x2, y2;
  logic signed [15:0] dx, dy, mn;
  int k;
  always #2 sys_clk = ~sys_clk;
  spg_engine #(.MS_CYCLES(10), .CH_W(8)) spg_engine_inst (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .cycle_stb_i(stb), .touch_i(touch),
    .pos_x_i(px), .pos_y_i(py), .ch_count_i(cnt),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .gesture_o(gest), .gesture_event_o(evt));
  spg_host spg_host_inst (
    .clk_i(sys_clk), .awaddr_o(s_axi_awaddr), .awvalid_o(s_axi_awvalid),
    .awready_i(s_axi_awready), .wdata_o(s_axi_wdata), .wstrb_o(s_axi_wstrb),
    .wvalid_o(s_axi_wvalid), .wready_i(s_axi_wready), .bresp_i(s_axi_bresp),
    .bvalid_i(s_axi_bvalid), .bready_o(s_axi_bready), .araddr_o(s_axi_araddr),
    .arvalid_o(s_axi_arvalid), .arready_i(s_axi_arready), .rdata_i(s_axi_rdata),
    .rresp_i(s_axi_rresp), .rvalid_i(s_axi_rvalid), .rready_o(s_axi_rready));
  // xorshift source of random stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected swipe flag: dominant axis, sign gives direction
  function automatic logic [3:0] dir(input logic signed [15:0] ex, input logic signed [15:0] ey);
    if ((ex < 0 ? -ex : ex) >= (ey < 0 ? -ey : ey)) return (ex > 0) ? 4'h1 : 4'h2;
    return (ey > 0) ? 4'h4 : 4'h8;
  endfunction
  task stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // bus access; a hung slave ends the run
  task bus(input bit w, input logic [7:0] a, input logic [31:0] v);
    if (w) host_inst_wr(a, v);
    else spg_host_inst.rd(a, dat, rsp, ok);
    if (!ok) begin
      failures++;
      stop_test();
    end
  endtask
  task host_inst_wr(input logic [7:0] a, input logic [31:0] v);
    spg_host_inst.wr(a, v, rsp, ok);
  endtask
  // one processing cycle; flags are settled when this returns
  task step(input logic t, input logic [15:0] x, input logic [15:0] y, input logic [7:0] c);
    @(posedge sys_clk);
    stb <= 1'b1;
    touch <= t;
    px <= x;
    py <= y;
    cnt <= c;
    @(posedge sys_clk);
    stb <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task swipe(input logic signed [15:0] sx, input logic signed [15:0] sy);
    step(1, 16'd1000, 16'd1000, 8'h01);
    step(1, 16'd1000 + sx, 16'd1000 + sy, 8'h01);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    bus(0, `SPG_OFS_ENABLE, 0);
    chk("enable", dat, `SPG_ENABLE_RST);
    bus(0, 8'h20, 0);
    chk("bad resp", rsp, 32'h2);
    chk("bad data", dat, 32'h0);
    bus(1, `SPG_OFS_TIMES, 32'h0004_0005); // hold 4 ms, swipe 5 ms
    bus(1, `SPG_OFS_ENABLE, 32'h0000_010F); // swipes and palm, no hold
    for (int i = 0; i < 8; i++) begin
      k = i % 4;
      d = 16'd100 + 16'(rnd() % 40);
      mn = 16'(rnd() % 41) - 16'd20;
      dx = (k == 0) ? d : (k == 1) ? -d : mn;
      dy = (k == 2) ? d : (k == 3) ? -d : mn;
      swipe(dx, dy);
      chk("swipe", gest[3:0], dir(dx, dy));
      bus(0, `SPG_OFS_REL, 0);
      chk("rel", dat, {dy, dx});
      step(1, 16'd1000 + dx, 16'd1000 + dy, 8'h01);
      chk("pulse", gest[3:0], 0);
      bus(0, `SPG_OFS_GEST, 0);
      chk("gest xy", dat, {dy, dx});
      repeat (15) step(1, 16'd1000 + dx, 16'd1000 + dy, 8'h01);
      x2 = 16'(16'd1000 + 2 * dx);
      y2 = 16'(16'd1000 + 2 * dy);
      step(1, x2, y2, 8'h01);
      chk("again", gest[3:0], dir(dx, dy));
      step(1, x2 + ((k < 2) ? 16'd0 : 16'd60), y2 + ((k < 2) ? 16'd60 : 16'd0), 8'h01);
      chk("cross", gest[3:0], 0);
      step(1, x2 + ((k < 2) ? 16'd0 : 16'd110), y2 + ((k < 2) ? 16'd110 : 16'd0), 8'h01);
      chk("cross2", gest[3:0], (k < 2) ? 4'h4 : 4'h1);
      step(0, 0, 0, 0);
    end
    step(1, 16'd1000, 16'd1000, 8'h01);
    repeat (15) step(1, 16'd1000, 16'd1000, 8'h01);
    step(1, 16'd1120, 16'd1000, 8'h01);
    chk("late", gest[3:0], 0);
    // a late hit must stay refused for the rest of the touch
    step(1, 16'd1120, 16'd1000, 8'h01);
    chk("late again", gest[3:0], 0);
    step(0, 0, 0, 0);
    bus(1, `SPG_OFS_ENABLE, 32'h0000_010E);
    swipe(16'sd120, 16'sd0);
    chk("masked", gest[3:0], 0);
    step(0, 0, 0, 0);
    bus(1, `SPG_OFS_ENABLE, 32'h0000_010F);
    bus(1, `SPG_OFS_LIMITS, 32'h0014_1420); // angle 32
    swipe(16'sd100, 16'sd51);
    chk("wide", gest[3:0], 0);
    step(0, 0, 0, 0);
    swipe(16'sd100, 16'sd50);
    chk("edge", gest[3:0], 4'h1);
    step(0, 0, 0, 0);
    bus(1, `SPG_OFS_LIMITS, `SPG_LIMITS_RST);
    bus(1, `SPG_OFS_ENABLE, 32'h0000_011F);
    swipe(16'sd120, 16'sd0);
    repeat (5) step(1, 16'd1120, 16'd1000, 8'h01);
    chk("hold early", gest[8:4], 5'h00);
    repeat (9) step(1, 16'd1120, 16'd1000, 8'h01);
    chk("hold", gest[8:4], 5'h01);
    step(1, 16'd1500, 16'd1000, 8'h01);
    chk("hold kept", gest[8:4], 5'h01);
    step(0, 0, 0, 0);
    chk("hold gone", gest[8:4], 5'h00);
    step(1, 16'd1000, 16'd1000, 8'd19);
    chk("palm low", gest[8], 0);
    step(1, 16'd1000, 16'd1000, 8'd20);
    chk("palm", gest[8], 1);
    step(1, 16'd1000, 16'd1000, 8'd3);
    chk("palm kept", gest[8], 1);
    step(0, 0, 0, 0);
    chk("palm gone", gest[8], 0);
    bus(1, `SPG_OFS_ENABLE, 32'h0000_030F);
    swipe(16'sd0, 16'sd120);
    chk("event", evt, 1);
    step(0, 0, 0, 0);
    bus(0, `SPG_OFS_STATUS, 0);
    chk("status ev", dat[9], 1);
    bus(1, `SPG_OFS_STATUS, 32'h0000_0200);
    bus(0, `SPG_OFS_STATUS, 0);
    chk("ev clear", {dat[9], evt}, 0);
    stop_test();
  end
endmodule
